/* hw/kpm_defines.svh */
// offsets, field positions, reset values and timing for the keypad menu
// Contract
// [R1] Enter menu only after mode and fan keys held together 5 s.
// [R2] Each parameter is a pair: function class code, then setting code.
// [R3] Class starts at 0 on entry; up/down change only the setting code.
// [R4] Confirm stores the setting and advances to the next defined class.
// [R5] Confirm while class is 6 leaves the menu, back to normal operation.
// [R6] Class 0: setting 0 cool-and-heat (default), 1 cool-only.
// [R7] Class 3: off, 1250, 2500, 5000, 10000 hours; 2500 is default.
// [R8] Operator uses the menu only when a default must change.
// [R9] Classes 1,2,5: 0 enable (default), 1 disable; 6 unit; 4 skipped.
// [R10] With cool-only configured, the mode key cycle omits heating.
`ifndef KPM_DEFINES_SVH
`define KPM_DEFINES_SVH

// register byte offsets
`define KPM_CTRL_OFFSET 8'h00
`define KPM_STATUS_OFFSET 8'h04
`define KPM_CONFIG_OFFSET 8'h08

// ctrl fields
`define KPM_CTRL_LOCK_BIT 0
`define KPM_CTRL_ABORT_BIT 1

// status fields
`define KPM_ST_ACTIVE_BIT 0
`define KPM_ST_CLASS_LSB 4
`define KPM_ST_SETTING_LSB 8
`define KPM_ST_MODE_LSB 12

// config fields
`define KPM_CFG_COOL_ONLY_BIT 0
`define KPM_CFG_ADDR_DIS_BIT 1
`define KPM_CFG_RESTART_DIS_BIT 2
`define KPM_CFG_FILTER_LSB 4
`define KPM_CFG_REMOTE_DIS_BIT 8
`define KPM_CFG_FAHRENHEIT_BIT 9

// class codes and setting limits
`define KPM_CLASS_COOL 4'h0
`define KPM_CLASS_ADDR 4'h1
`define KPM_CLASS_RESTART 4'h2
`define KPM_CLASS_FILTER 4'h3
`define KPM_CLASS_REMOTE 4'h5
`define KPM_CLASS_UNIT 4'h6
`define KPM_CLASS_FIRST 4'h0
`define KPM_FILTER_MAX 4'h4
`define KPM_BINARY_MAX 4'h1

// reset values
`define KPM_FILTER_DEFAULT 3'h2
`define KPM_BIT_DEFAULT 1'b0

// timing
`define KPM_CLK_MHZ 100
`define KPM_HOLD_TIME_MS 5000
`define KPM_HOLD_CYCLES (`KPM_HOLD_TIME_MS * 1000 * `KPM_CLK_MHZ)

// axi responses
`define KPM_RESP_OKAY 2'h0
`define KPM_RESP_SLVERR 2'h2

`endif

/* hw/kpm_pkg.sv */
// types shared by the keypad menu
package kpm_pkg;
    typedef enum logic [0:0] {
        KPM_IDLE = 1'b0,
        KPM_MENU = 1'b1
    } kpm_state_t;

    typedef enum logic [2:0] {
        KPM_AUTO = 3'b000,
        KPM_COOL = 3'b001,
        KPM_DRY = 3'b010,
        KPM_HEAT = 3'b011,
        KPM_FAN = 3'b100
    } kpm_opmode_t;

    typedef enum logic [1:0] {
        KPM_REG_CTRL = 2'b00,
        KPM_REG_STATUS = 2'b01,
        KPM_REG_CONFIG = 2'b10,
        KPM_REG_NONE = 2'b11
    } kpm_reg_t;
endpackage

/* hw/kpm_hold_timer.sv */
// two-key hold timer: one pulse after a continuous hold of HOLD_CYCLES
`timescale 1ns/1ps
module kpm_hold_timer #(
    parameter int unsigned HOLD_CYCLES = 32'd500000000
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // keys held together
    input wire logic hold_in,
    // one-cycle pulse when the hold time is reached
    output logic fire
);
    logic [31:0] cnt_reg;

    // count saturates so a long hold fires only once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 32'h0;
        end else if (!hold_in) begin
            cnt_reg <= 32'h0;
        end else if (cnt_reg != HOLD_CYCLES) begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fire <= 1'b0;
        end else begin
            fire <= hold_in && (cnt_reg == HOLD_CYCLES - 32'h1); // [R1]
        end
    end
endmodule

/* hw/kpm_menu.sv */
// keypad parameter menu with axi4-lite status and control registers
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "kpm_defines.svh"
module kpm_menu import kpm_pkg::*; #(
    parameter int unsigned HOLD_CYCLES = `KPM_HOLD_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // front-panel keys, high while pressed
    input wire logic key_mode,
    input wire logic key_fan,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_ok,
    // menu display
    output logic menu_active,
    output logic [3:0] class_code,
    output logic [3:0] setting_code,
    // stored settings and operating mode
    output logic cool_only,
    output logic addr_set_dis,
    output logic restart_dis,
    output logic [2:0] filter_sel,
    output logic remote_dis,
    output logic fahrenheit,
    output logic [2:0] op_mode,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    kpm_state_t state_reg;
    logic [4:0] keys_prev_reg;
    logic [4:0] keys_now;
    logic [4:0] press;
    logic hold_fire;
    logic lock_reg;
    logic abort_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    localparam int K_MODE = 0;
    localparam int K_FAN = 1;
    localparam int K_UP = 2;
    localparam int K_DOWN = 3;
    localparam int K_OK = 4;

    // highest legal setting code of a class
    function automatic logic [3:0] max_setting(input logic [3:0] cls);
        if (cls == `KPM_CLASS_FILTER) begin
            max_setting = `KPM_FILTER_MAX; // [R7]
        end else begin
            max_setting = `KPM_BINARY_MAX; // [R6] [R9]
        end
    endfunction

    // next defined class; class 4 has no parameter
    function automatic logic [3:0] next_class(input logic [3:0] cls);
        if (cls == `KPM_CLASS_FILTER) begin
            next_class = `KPM_CLASS_REMOTE; // [R9]
        end else begin
            next_class = cls + 4'h1; // [R4]
        end
    endfunction

    // setting currently stored for a class, shown when the class comes up
    function automatic logic [3:0] stored_setting(input logic [3:0] cls,
            input logic [9:0] cfg);
        case (cls)
            `KPM_CLASS_COOL: stored_setting = {3'h0, cfg[0]};
            `KPM_CLASS_ADDR: stored_setting = {3'h0, cfg[1]};
            `KPM_CLASS_RESTART: stored_setting = {3'h0, cfg[2]};
            `KPM_CLASS_FILTER: stored_setting = {1'b0, cfg[6:4]};
            `KPM_CLASS_REMOTE: stored_setting = {3'h0, cfg[8]};
            `KPM_CLASS_UNIT: stored_setting = {3'h0, cfg[9]};
            default: stored_setting = 4'h0;
        endcase
    endfunction

    // register decode shared by read and write paths
    function automatic kpm_reg_t reg_decode(input logic [7:0] addr);
        case (addr)
            `KPM_CTRL_OFFSET: reg_decode = KPM_REG_CTRL;
            `KPM_STATUS_OFFSET: reg_decode = KPM_REG_STATUS;
            `KPM_CONFIG_OFFSET: reg_decode = KPM_REG_CONFIG;
            default: reg_decode = KPM_REG_NONE;
        endcase
    endfunction

    // mode key cycle: auto, cool, dry, heat, fan
    function automatic logic [2:0] next_mode(input logic [2:0] m,
            input logic cool_only_in);
        case (m)
            KPM_AUTO: next_mode = KPM_COOL;
            KPM_COOL: next_mode = KPM_DRY;
            KPM_DRY: next_mode = cool_only_in ? KPM_FAN : KPM_HEAT; // [R10]
            KPM_HEAT: next_mode = KPM_FAN;
            default: next_mode = KPM_AUTO;
        endcase
    endfunction

    logic [9:0] cfg_vec;
    assign cfg_vec = {fahrenheit, remote_dis, 1'b0, filter_sel, 1'b0,
        restart_dis, addr_set_dis, cool_only};

    // keys are synchronous levels; a press is a rising edge
    assign keys_now = {key_ok, key_down, key_up, key_fan, key_mode};
    assign press = keys_now & ~keys_prev_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            keys_prev_reg <= 5'h0;
        end else begin
            keys_prev_reg <= keys_now;
        end
    end

    kpm_hold_timer #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_hold (
        .aclk(aclk),
        .aresetn(aresetn),
        .hold_in(key_mode && key_fan), // [R1]
        .fire(hold_fire)
    );

    // menu state and the class/setting pair under edit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= KPM_IDLE;
            class_code <= `KPM_CLASS_FIRST;
            setting_code <= 4'h0;
        end else begin
            case (state_reg)
                KPM_IDLE: begin
                    if (hold_fire && !lock_reg) begin
                        state_reg <= KPM_MENU; // [R1]
                        class_code <= `KPM_CLASS_FIRST; // [R3]
                        setting_code <= stored_setting(`KPM_CLASS_FIRST,
                            cfg_vec); // [R2]
                    end
                end
                KPM_MENU: begin
                    if (abort_reg) begin
                        state_reg <= KPM_IDLE;
                    end else if (press[K_OK]) begin
                        if (class_code == `KPM_CLASS_UNIT) begin
                            state_reg <= KPM_IDLE; // [R5]
                        end else begin
                            class_code <= next_class(class_code); // [R4]
                            setting_code <= stored_setting(
                                next_class(class_code), cfg_vec);
                        end
                    end else if (press[K_UP] && !press[K_DOWN]) begin
                        if (setting_code != max_setting(class_code)) begin
                            setting_code <= setting_code + 4'h1; // [R3]
                        end
                    end else if (press[K_DOWN] && !press[K_UP]) begin
                        if (setting_code != 4'h0) begin
                            setting_code <= setting_code - 4'h1; // [R3]
                        end
                    end
                end
                default: state_reg <= KPM_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            menu_active <= 1'b0;
        end else begin
            menu_active <= (state_reg == KPM_MENU);
        end
    end

    // confirm stores the shown setting into its class; defaults at reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cool_only <= `KPM_BIT_DEFAULT; // [R6]
            addr_set_dis <= `KPM_BIT_DEFAULT; // [R9]
            restart_dis <= `KPM_BIT_DEFAULT;
            filter_sel <= `KPM_FILTER_DEFAULT; // [R7]
            remote_dis <= `KPM_BIT_DEFAULT;
            fahrenheit <= `KPM_BIT_DEFAULT;
        end else if (state_reg == KPM_MENU && press[K_OK] && !abort_reg) begin
            case (class_code)
                `KPM_CLASS_COOL: cool_only <= setting_code[0]; // [R4] [R6]
                `KPM_CLASS_ADDR: addr_set_dis <= setting_code[0]; // [R9]
                `KPM_CLASS_RESTART: restart_dis <= setting_code[0];
                `KPM_CLASS_FILTER: filter_sel <= setting_code[2:0]; // [R7]
                `KPM_CLASS_REMOTE: remote_dis <= setting_code[0];
                `KPM_CLASS_UNIT: fahrenheit <= setting_code[0];
                default: fahrenheit <= fahrenheit;
            endcase
        end
    end

    // operating mode; keys belong to the menu while it is open
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_mode <= KPM_AUTO;
        end else if (cool_only && op_mode == KPM_HEAT) begin
            op_mode <= KPM_COOL; // [R10]
        end else if (state_reg == KPM_IDLE && press[K_MODE]) begin
            op_mode <= next_mode(op_mode, cool_only); // [R10]
        end
    end

    // axi write: address and data taken in either order, then one response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 8'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `KPM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (!aw_got_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (!w_got_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (reg_decode(awaddr_reg) == KPM_REG_NONE) ?
                    `KPM_RESP_SLVERR : `KPM_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_fire;
    assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid &&
        reg_decode(awaddr_reg) == KPM_REG_CTRL && wstrb_reg[0];

    // lock keeps the menu shut; abort is a self-clearing exit request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            abort_reg <= wr_fire && wdata_reg[`KPM_CTRL_ABORT_BIT];
            if (wr_fire) begin
                lock_reg <= wdata_reg[`KPM_CTRL_LOCK_BIT];
            end
        end
    end

    // axi read: one outstanding read, data one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `KPM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `KPM_RESP_OKAY;
            s_axi_rdata <= 32'h0;
            case (reg_decode(s_axi_araddr))
                KPM_REG_CTRL: s_axi_rdata[`KPM_CTRL_LOCK_BIT] <= lock_reg;
                KPM_REG_STATUS: s_axi_rdata[15:0] <= {1'b0, op_mode,
                    setting_code, class_code, 3'h0,
                    state_reg == KPM_MENU};
                KPM_REG_CONFIG: s_axi_rdata[9:0] <= cfg_vec;
                default: s_axi_rresp <= `KPM_RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

/* bench/kpm_menu_chk.sv */
// concurrent checks on the keypad menu ports
`timescale 1ns/1ps
module kpm_menu_chk import kpm_pkg::*; #(
    parameter int unsigned HOLD_CYCLES = 20
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // keys
    input wire logic key_mode,
    input wire logic key_fan,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_ok,
    // menu, stored settings and operating mode
    input wire logic menu_active,
    input wire logic [3:0] class_code,
    input wire logic [3:0] setting_code,
    input wire logic cool_only,
    input wire logic [2:0] filter_sel,
    input wire logic [2:0] op_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic ok_q, up_q, reached;
    logic [31:0] hold_cnt;
    logic [3:0] exp_next, set_q, rel_cnt;
    wire ok_press = key_ok && !ok_q && menu_active;
    wire up_press = key_up && !up_q && !key_down && !key_ok && menu_active;
    always_ff @(posedge aclk) begin
        ok_q <= key_ok;
        up_q <= key_up;
        set_q <= setting_code;
        exp_next <= (class_code == 4'h3) ? 4'h5 : class_code + 4'h1;
    end
    // counts consecutive cycles with both keys down
    always_ff @(posedge aclk) begin
        if (!aresetn || !(key_mode && key_fan)) hold_cnt <= 32'h0;
        else hold_cnt <= hold_cnt + 32'h1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || (key_mode && key_fan)) rel_cnt <= 4'h0;
        else if (rel_cnt != 4'h8) rel_cnt <= rel_cnt + 4'h1;
    end
    // stays set a few cycles after release, since the open shows late
    always_ff @(posedge aclk) begin
        if (!aresetn) reached <= 1'b0;
        else if (key_mode && key_fan && hold_cnt >= HOLD_CYCLES - 1)
            reached <= 1'b1;
        else if (menu_active || rel_cnt == 4'h8) reached <= 1'b0;
    end
    sequence s_ok_at(logic [3:0] c);
        ok_press && class_code == c;
    endsequence
    a_hold_before_open: assert property (
        $rose(menu_active) |-> reached) else $error("menu opened early");
    a_open_at_zero: assert property (
        $rose(menu_active) |-> class_code == 4'h0)
        else $error("menu opened off class zero");
    a_class_defined: assert property (
        menu_active |-> class_code != 4'h4 && class_code <= 4'h6)
        else $error("undefined class shown");
    a_setting_bound: assert property (
        menu_active |-> setting_code <= ((class_code == 4'h3) ? 4'h4 : 4'h1))
        else $error("setting beyond its range");
    a_up_steps: assert property (
        up_press && setting_code < ((class_code == 4'h3) ? 4'h4 : 4'h1)
        |=> setting_code == $past(setting_code) + 4'h1)
        else $error("up press did not step setting");
    a_ok_advance: assert property (
        ok_press && class_code != 4'h6 |=> class_code == exp_next)
        else $error("confirm did not advance class");
    a_ok_exit: assert property (
        s_ok_at(4'h6) |-> ##[1:2] !menu_active)
        else $error("menu did not close after last class");
    a_store_cool: assert property (
        s_ok_at(4'h0) |=> cool_only == set_q[0])
        else $error("cooling selection not stored");
    a_store_filter: assert property (
        s_ok_at(4'h3) |=> filter_sel == set_q[2:0])
        else $error("filter interval not stored");
    a_no_heat: assert property (
        cool_only && $past(cool_only) |-> op_mode != KPM_HEAT)
        else $error("heating mode while cool-only");
endmodule

bind kpm_menu kpm_menu_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .key_mode(key_mode),
    .key_fan(key_fan), .key_up(key_up), .key_down(key_down),
    .key_ok(key_ok), .menu_active(menu_active), .class_code(class_code),
    .setting_code(setting_code), .cool_only(cool_only),
    .filter_sel(filter_sel), .op_mode(op_mode)
);

/* bench/kpm_operator.sv */
// operator at the front panel pressing keys
`timescale 1ns/1ps
module kpm_operator (
    // clock
    input wire logic aclk,
    // keys, high while pressed
    output logic key_mode,
    output logic key_fan,
    output logic key_up,
    output logic key_down,
    output logic key_ok
);
    logic [4:0] k;
    initial k = 5'h00;
    assign {key_ok, key_down, key_up, key_fan, key_mode} = k;
    // two cycles down, two up, so each press is one clean rising edge
    task automatic tap(input int i);
        @(posedge aclk);
        k[i] <= 1'b1;
        repeat (2) @(posedge aclk);
        k[i] <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    // opened only when a default is to be changed
    task automatic hold(input int n);
        @(posedge aclk);
        k[1:0] <= 2'b11;
        repeat (n) @(posedge aclk);
        k[1:0] <= 2'b00;
        repeat (4) @(posedge aclk);
    endtask
endmodule

/* bench/tb.sv */
// register and keypad sequences for the keypad menu
`timescale 1ns/1ps
`include "kpm_defines.svh"
module tb import kpm_pkg::*; ;
    localparam int HOLD = 20;
    localparam logic [3:0] CLS [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
    localparam logic [3:0] UPS [6] = '{4'h2, 4'h1, 4'h0, 4'h3, 4'h1, 4'h1};
    localparam logic [3:0] SET [6] = '{4'h1, 4'h1, 4'h0, 4'h4, 4'h1, 4'h1};
    logic aclk, aresetn, key_mode, key_fan, key_up, key_down, key_ok;
    logic menu_active, cool_only, addr_set_dis, restart_dis;
    logic remote_dis, fahrenheit;
    logic [3:0] class_code, setting_code;
    logic [2:0] filter_sel, op_mode;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    int error_cnt, cmp_count;

    kpm_menu #(.HOLD_CYCLES(HOLD)) DUT (
        .aclk(aclk), .aresetn(aresetn), .key_mode(key_mode),
        .key_fan(key_fan), .key_up(key_up), .key_down(key_down),
        .key_ok(key_ok), .menu_active(menu_active),
        .class_code(class_code), .setting_code(setting_code),
        .cool_only(cool_only), .addr_set_dis(addr_set_dis),
        .restart_dis(restart_dis), .filter_sel(filter_sel),
        .remote_dis(remote_dis), .fahrenheit(fahrenheit), .op_mode(op_mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    kpm_operator op (
        .aclk(aclk), .key_mode(key_mode), .key_fan(key_fan),
        .key_up(key_up), .key_down(key_down), .key_ok(key_ok)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input string n, input logic [31:0] g,
                       input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        r = 2'h3;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64 && r === 2'h3; n++) begin
            @(posedge aclk);
            if (aw_ok && w_ok && bvalid) r = bresp;
            if (!aw_ok && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        if (r === 2'h3) begin
            error_cnt++;
            print_verdict();
        end
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        bit ar_ok;
        ar_ok = 0;
        r = 2'h3;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64 && r === 2'h3; n++) begin
            @(posedge aclk);
            if (ar_ok && rvalid) begin
                d = rdata;
                r = rresp;
            end
            if (!ar_ok && arready) begin
                ar_ok = 1;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
        if (r === 2'h3) begin
            error_cnt++;
            print_verdict();
        end
        @(posedge aclk);
    endtask

    initial begin
        repeat (30000) @(posedge aclk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        aresetn = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        error_cnt = 0;
        cmp_count = 0;
        wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("filter_sel", 32'(filter_sel), 32'h2);
        chk("cool_only", 32'(cool_only), 32'h0);
        axi_read(`KPM_CONFIG_OFFSET, rd, rr);
        chk("config", rd, 32'h20);
        axi_read(8'h0c, rd, rr);
        chk("bad read resp", 32'(rr), 32'(`KPM_RESP_SLVERR));
        axi_write(8'h0c, 32'h1, rr);
        chk("bad write resp", 32'(rr), 32'(`KPM_RESP_SLVERR));
        // a lock write with its low byte masked must not take
        wstrb <= 4'h0;
        axi_write(`KPM_CTRL_OFFSET, 32'h1, rr);
        wstrb <= 4'hf;
        axi_write(`KPM_STATUS_OFFSET, 32'h1, rr);
        chk("ro write resp", 32'(rr), 32'(`KPM_RESP_OKAY));
        axi_read(`KPM_CTRL_OFFSET, rd, rr);
        chk("masked lock", rd, 32'h0);
        for (int i = 1; i <= 5; i++) begin
            op.tap(0);
            chk("op_mode", 32'(op_mode), 32'(i % 5));
        end
        op.hold(HOLD - 1);
        chk("short hold", 32'(menu_active), 32'h0);
        axi_write(`KPM_CTRL_OFFSET, 32'h1, rr);
        axi_read(`KPM_CTRL_OFFSET, rd, rr);
        chk("lock", rd, 32'h1);
        op.hold(HOLD + 2);
        chk("locked hold", 32'(menu_active), 32'h0);
        axi_write(`KPM_CTRL_OFFSET, 32'h0, rr);
        op.hold(HOLD + 2);
        chk("menu open", 32'(menu_active), 32'h1);
        // each hold also pressed mode while idle: auto to heat by now
        axi_read(`KPM_STATUS_OFFSET, rd, rr);
        chk("status", rd, 32'h3001);
        for (int i = 0; i < 6; i++) begin
            chk("class", 32'(class_code), 32'(CLS[i]));
            repeat (UPS[i]) op.tap(2);
            chk("setting", 32'(setting_code), 32'(SET[i]));
            op.tap(4);
        end
        chk("menu closed", 32'(menu_active), 32'h0);
        axi_read(`KPM_CONFIG_OFFSET, rd, rr);
        chk("config", rd, 32'h343);
        chk("stored", 32'({fahrenheit, remote_dis, restart_dis,
            addr_set_dis, cool_only, filter_sel}), 32'hdc);
        for (int f = 0; f < 5; f++) begin
            op.hold(HOLD + 2);
            chk("entry setting", 32'(setting_code), 32'h1);
            repeat (3) op.tap(4);
            chk("filter class", 32'(class_code), 32'h3);
            repeat (4) op.tap(3);
            repeat (f) op.tap(2);
            op.tap(4);
            chk("filter_sel", 32'(filter_sel), 32'(f));
            axi_write(`KPM_CTRL_OFFSET, 32'h2, rr);
            repeat (3) @(posedge aclk);
            chk("aborted", 32'(menu_active), 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            op.tap(0);
            chk("heat skipped", 32'(op_mode === KPM_HEAT), 32'h0);
        end
        print_verdict();
    end
endmodule
